// ===== design/mcc_cfg_map.vh
// constants for the main configuration low register fields
`ifndef MCC_CFG_MAP_VH
`define MCC_CFG_MAP_VH
`define MCC_CFG_WIDTH 16
`define MCC_CFG_RESET 16'h0000
`define MCC_BIT_EXTREF 15
`define MCC_BIT_MERGE 12
`define MCC_BIT_BURST 11
`define MCC_BIT_DSMODE 10
`define MCC_BIT_SETTLE_HI 9
`define MCC_BIT_SETTLE_LO 8
`define MCC_BIT_ACCCLR 5
`define MCC_BIT_PIN4_HI 3
`define MCC_BIT_PIN4_LO 2
`define MCC_BIT_PIN3 1
`define MCC_BIT_SOFTWARE_RESET_TRIGGER 0
`define MCC_RW_MASK 16'h9F0E
`define MCC_BURST_A_LO 16'h0500
`define MCC_BURST_A_HI 16'h063C
`define MCC_BURST_B_LO 16'h0680
`define MCC_BURST_B_HI 16'h06BC
`define MCC_SETTLE0_MS 64
`define MCC_SETTLE1_MS 128
`define MCC_SETTLE2_MS 256
`define MCC_CLK_KHZ 40000
`define MCC_PIN4_EVENT 2'h2
`define MCC_PIN4_READY 2'h3
`endif

// ===== design/mcc_settle_timer.v
// settle delay counter gating accumulation start
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg_map.vh"
module mcc_settle_timer #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] CYC0 = `MCC_SETTLE0_MS * `MCC_CLK_KHZ,
	parameter [CNT_W-1:0] CYC1 = `MCC_SETTLE1_MS * `MCC_CLK_KHZ,
	parameter [CNT_W-1:0] CYC2 = `MCC_SETTLE2_MS * `MCC_CLK_KHZ
) (
	// clocking
	input wire clk,
	input wire nrst,
	input wire ce,
	// control
	input wire restart,
	input wire [1:0] settleSel,
	// status
	output wire accumEnable
);
	// =====================================
	// counter
	reg [CNT_W-1:0] cnt_ff;
	reg done_ff;
	reg [CNT_W-1:0] limit;
	always @* begin
		case (settleSel)
			2'h0: limit = CYC0;
			2'h1: limit = CYC1;
			2'h2: limit = CYC2;
			default: limit = {CNT_W{1'b0}};
		endcase
	end
	always @(posedge clk) begin
		if (!nrst) begin
			cnt_ff <= {CNT_W{1'b0}};
			done_ff <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				cnt_ff <= {CNT_W{1'b0}};
				done_ff <= 1'b0;
			end else if (!done_ff) begin
				if (cnt_ff >= limit) begin
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
	assign accumEnable = done_ff;
endmodule
`default_nettype wire

// ===== design/mcc_config_low.v
// main configuration low register with its control effects
`timescale 1ns/1ps
`default_nettype none
`include "mcc_cfg_map.vh"
// Functional notes
// - merge bit twelve routes all events to pin two
// - pin one keeps own events when merged
// - burst bit permits burst reads in ranges
// - burst bit drops read CRC word
// - dip mode zero: interrupt every cycle count
// - dip mode one: interrupt entry and exit
// - settle code sets accumulation start delay
// - accumulator clear zeroes converter and denominator
// - accumulator clear bit self clears
// - pin four: event, ready, or pulse four
// - pin three: pulse three or zero cross
// - software reset bit performs reset, self clears
module mcc_config_low #(
	parameter CNT_W = 24
) (
	// clocking
	input wire clk,
	input wire nrst,
	input wire ce,
	// register port
	input wire regWrite,
	input wire [15:0] regWdata,
	output reg [15:0] regRdata,
	// read request address for burst/crc decisions
	input wire [15:0] readAddr,
	output wire burstAllowed,
	output wire appendCrc,
	// interrupt sources
	input wire irqOneEvents,
	input wire irqTwoEvents,
	output reg firstIrqPin,
	output reg secondIrqPin,
	// dip/swell
	input wire sagSurgeCountDone,
	input wire sagSurgeEnter,
	input wire sagSurgeExit,
	output reg sagSurgeIrq,
	// accumulation
	output wire accumEnable,
	output reg pulseAccClear,
	// pulse pins
	input wire pulseFour,
	input wire pulseThree,
	input wire eventInd,
	input wire sampleReady,
	input wire zeroCross,
	output reg pulseOutputFour,
	output reg pulseOutputThree,
	// soft reset
	output reg softReset
);
	// =====================================
	// register storage
	reg [15:0] cfg_ff;
	wire [15:0] nxt_cfg;
	wire wr;
	assign wr = ce & regWrite;
	assign nxt_cfg = regWdata & `MCC_RW_MASK;
	always @(posedge clk) begin
		if (!nrst || (ce && softReset)) begin
			cfg_ff <= `MCC_CFG_RESET;
		end else if (wr) begin
			cfg_ff <= nxt_cfg;
		end
	end
	// the clear and reset bits are pulses, never stored, so they read as zero
	always @(posedge clk) begin
		if (!nrst) begin
			regRdata <= 16'h0000;
		end else if (ce) begin
			regRdata <= cfg_ff & `MCC_RW_MASK;
		end
	end
	// =====================================
	// self clearing actions
	always @(posedge clk) begin
		if (!nrst) begin
			pulseAccClear <= 1'b0;
			softReset <= 1'b0;
		end else if (ce) begin
			pulseAccClear <= wr & regWdata[`MCC_BIT_ACCCLR];
			softReset <= wr & regWdata[`MCC_BIT_SOFTWARE_RESET_TRIGGER];
		end
	end
	// =====================================
	// burst and crc
	function inRange;
		input [15:0] a;
		begin
			inRange = (a >= `MCC_BURST_A_LO && a <= `MCC_BURST_A_HI) ||
				(a >= `MCC_BURST_B_LO && a <= `MCC_BURST_B_HI);
		end
	endfunction
	assign burstAllowed = cfg_ff[`MCC_BIT_BURST] & inRange(readAddr);
	assign appendCrc = ~cfg_ff[`MCC_BIT_BURST];
	// =====================================
	// interrupt pins and dip/swell
	always @(posedge clk) begin
		if (!nrst) begin
			firstIrqPin <= 1'b0;
			secondIrqPin <= 1'b0;
			sagSurgeIrq <= 1'b0;
		end else if (ce) begin
			firstIrqPin <= irqOneEvents;
			if (cfg_ff[`MCC_BIT_MERGE]) begin
				secondIrqPin <= irqOneEvents | irqTwoEvents;
			end else begin
				secondIrqPin <= irqTwoEvents;
			end
			if (cfg_ff[`MCC_BIT_DSMODE]) begin
				sagSurgeIrq <= sagSurgeEnter | sagSurgeExit;
			end else begin
				sagSurgeIrq <= sagSurgeCountDone;
			end
		end
	end
	// =====================================
	// pulse pin routing
	always @(posedge clk) begin
		if (!nrst) begin
			pulseOutputFour <= 1'b0;
			pulseOutputThree <= 1'b0;
		end else if (ce) begin
			case (cfg_ff[`MCC_BIT_PIN4_HI:`MCC_BIT_PIN4_LO])
				`MCC_PIN4_EVENT: pulseOutputFour <= eventInd;
				`MCC_PIN4_READY: pulseOutputFour <= sampleReady;
				default: pulseOutputFour <= pulseFour;
			endcase
			pulseOutputThree <= cfg_ff[`MCC_BIT_PIN3] ? zeroCross : pulseThree;
		end
	end
	// =====================================
	// settle timer restarts on reset, clear or settle change
	wire restartSettle;
	assign restartSettle = pulseAccClear | softReset |
		(wr && nxt_cfg[9:8] != cfg_ff[9:8]);
	mcc_settle_timer #(
		.CNT_W(CNT_W)
	) uSettle (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.restart(restartSettle),
		.settleSel(cfg_ff[`MCC_BIT_SETTLE_HI:`MCC_BIT_SETTLE_LO]),
		.accumEnable(accumEnable)
	);
endmodule
`default_nettype wire

// ===== tb/mcc_host_model.sv
// host model issuing register writes
`timescale 1ns/1ps
`default_nettype none
module mcc_host_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [15:0] reqData,
	output logic regWrite = 1'b0,
	output logic [15:0] regWdata = 16'h0000
);
	// idle data inverts so a stale word never looks valid
	always @(posedge clk) begin
		regWrite <= req;
		regWdata <= req ? reqData : ~regWdata;
	end
endmodule
`default_nettype wire

// ===== tb/mcc_config_low_monitor.sv
// assertions on the configuration low register ports
`timescale 1ns/1ps
`default_nettype none
module mcc_config_low_monitor (
	input wire logic clk, nrst, ce, regWrite, appendCrc, irqOneEvents, secondIrqPin,
	input wire logic sagSurgeCountDone, sagSurgeIrq, pulseAccClear, softReset, zeroCross,
	input wire logic sagSurgeEnter, sagSurgeExit,
	input wire logic pulseFour, pulseThree, eventInd, sampleReady,
	input wire logic pulseOutputFour, pulseOutputThree,
	input wire logic [15:0] regWdata, regRdata
);
	// regRdata one cycle later mirrors the live config
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_one(x); x ##1 !x; endsequence
	property p_mrg; ce && irqOneEvents ##1 regRdata[12] |-> secondIrqPin; endproperty
	a_mrg: assert property (p_mrg) else $error("merge");
	property p_crc; $past(ce) && $past(nrst) |-> $past(appendCrc) != regRdata[11]; endproperty
	a_crc: assert property (p_crc) else $error("crc");
	property p_clr; ce && regWrite && regWdata[5] |=> s_one(pulseAccClear); endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_rst; ce && regWrite && regWdata[0] |=> s_one(softReset) ##[1:3]
		regRdata == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("soft reset");
	property p_p3; ce ##1 1 |-> pulseOutputThree ==
		(regRdata[1] ? $past(zeroCross) : $past(pulseThree)); endproperty
	a_p3: assert property (p_p3) else $error("pin three");
	property p_p4; ce ##1 1 |-> pulseOutputFour == (regRdata[3] ? (regRdata[2] ?
		$past(sampleReady) : $past(eventInd)) : $past(pulseFour)); endproperty
	a_p4: assert property (p_p4) else $error("pin four");
	property p_rd0; (regRdata & 16'h60F1) == 16'h0000; endproperty
	a_rd0: assert property (p_rd0) else $error("read zero");
	property p_sag; ce && sagSurgeCountDone ##1 !regRdata[10] |-> sagSurgeIrq; endproperty
	a_sag: assert property (p_sag) else $error("sag");
	property p_sag1; ce && (sagSurgeEnter || sagSurgeExit) ##1 regRdata[10] |-> sagSurgeIrq;
	endproperty
	a_sag1: assert property (p_sag1) else $error("sag edge");
endmodule
bind mcc_config_low mcc_config_low_monitor u_mon (.*);
`default_nettype wire

// ===== tb/tb_metering_config_control_bits.sv
// self-checking bench for the configuration low register
`timescale 1ns/1ps
`default_nettype none
module tb_metering_config_control_bits;
	logic clk = 0, nrst = 0, req = 0, irqOneEvents = 0, irqTwoEvents = 0, pulseFour = 0;
	logic eventInd = 0, sampleReady = 0, pulseThree = 0, zeroCross = 0, sagSurgeCountDone = 0;
	logic sagSurgeEnter = 0, sagSurgeExit = 0, ce = 1;
	logic [15:0] reqData = 16'h0000, readAddr = 16'h0000, regWdata, regRdata;
	logic regWrite, burstAllowed, appendCrc, firstIrqPin, secondIrqPin, sagSurgeIrq;
	logic accumEnable, pulseAccClear, pulseOutputFour, pulseOutputThree, softReset;
	int num_errors = 0, samples_checked = 0;
	// row: config, inputs {irq1 irq2 p4 ev rdy p3 zx}, outputs {pin1 pin2 out4 out3}
	logic [26:0] rows [10] = '{27'h000052B, 27'h080040C, 27'h0800204, 27'h0002102,
		27'h0004100, 27'h0004082, 27'h0006180, 27'h0006042, 27'h0001020, 27'h0001011};
	mcc_host_model host (.*);
	mcc_config_low DUT (.*, .ce(ce));
	always #12.5 clk = ~clk;
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [15:0] d);
		@(negedge clk) req = 1'b1;
		reqData = d;
		@(negedge clk) req = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic sg(logic [2:0] s, logic e);
		@(negedge clk) {sagSurgeCountDone, sagSurgeEnter, sagSurgeExit} = s;
		@(negedge clk) {sagSurgeCountDone, sagSurgeEnter, sagSurgeExit} = 3'h0;
		chk(sagSurgeIrq, e);
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ====
	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		chk(regRdata, 16'h0000);
		foreach (rows[k]) begin
			wr(rows[k][26:11]);
			{irqOneEvents, irqTwoEvents, pulseFour, eventInd, sampleReady, pulseThree,
				zeroCross} = rows[k][10:4];
			@(negedge clk) chk({firstIrqPin, secondIrqPin, pulseOutputFour,
				pulseOutputThree}, rows[k][3:0]);
			chk(regRdata, rows[k][26:11]);
		end
		wr(16'h0800);
		readAddr = 16'h06BC;
		@(negedge clk) chk({burstAllowed, appendCrc}, 2'h2);
		readAddr = 16'h0640;
		@(negedge clk) chk({burstAllowed, appendCrc}, 2'h0);
		wr(16'h0B22);
		chk(regRdata, 16'h0B02);
		chk(accumEnable, 1'b1);
		sg(3'h4, 1'b1);
		wr(16'h0401);
		chk(regRdata, 16'h0000);
		chk(accumEnable, 1'b0);
		wr(16'h0400);
		sg(3'h4, 1'b0);
		sg(3'h2, 1'b1);
		sg(3'h1, 1'b1);
		readAddr = 16'h0500;
		@(negedge clk) chk({burstAllowed, appendCrc}, 2'h1);
		@(negedge clk) req = 1'b1;
		reqData = 16'h0021;
		@(negedge clk) req = 1'b0;
		@(negedge clk) chk({pulseAccClear, softReset}, 2'h3);
		@(negedge clk) chk({pulseAccClear, softReset}, 2'h0);
		wr(16'h0002);
		ce = 1'b0;
		wr(16'h0000);
		ce = 1'b1;
		@(negedge clk) chk(regRdata, 16'h0002);
		finish_test();
	end
	// watchdog well past the expected run length
	initial begin
		#50000;
		num_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
